// [cpu_bus_pkg.sv]
/*
 * shared constants for the processor-side backplane interface: cycle kinds,
 * sequencer states, status bit positions, jumper codes and clock division.
 * assumes a single system clock standing in for the base oscillator.
 */
package cpu_bus_pkg;

	// base oscillator and the two derived bus rates
	localparam int OSC_HZ = 16_000_000;
	localparam int PHASE_HZ = 4_000_000;
	localparam int SLOW_HZ = 2_000_000;
	localparam int DIV_PHASE = OSC_HZ / PHASE_HZ;
	localparam int DIV_SLOW = OSC_HZ / SLOW_HZ;
	localparam int DIV_W = $clog2(DIV_SLOW);

	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int IRQ_N = 8;

	// status word bit positions; bit 5 is unused and reads zero
	localparam int ST_MEMR = 0;
	localparam int ST_INP = 1;
	localparam int ST_M1 = 2;
	localparam int ST_OUT = 3;
	localparam int ST_HLTA = 4;
	localparam int ST_WO = 6;
	localparam int ST_INTA = 7;

	// wait_state_jumper codes
	localparam logic [1:0] WAIT_ONE = 2'h1;
	localparam logic [1:0] WAIT_TWO = 2'h2;
	localparam logic [1:0] WAIT_CNT_ONE = 2'h1;
	localparam logic [1:0] WAIT_CNT_TWO = 2'h2;

	localparam logic [7:0] RESTART_LOW = 8'h00;
	localparam logic [7:0] IO_HIGH = 8'h00;

	typedef enum logic [2:0] {
		CYC_MEM_RD = 3'h0,
		CYC_MEM_WR = 3'h1,
		CYC_IO_IN = 3'h2,
		CYC_IO_OUT = 3'h3,
		CYC_FETCH = 3'h4,
		CYC_INT_ACK = 3'h5,
		CYC_HALT = 3'h6
	} cyc_kind_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_T1 = 3'h1,
		ST_T2 = 3'h2,
		ST_TW = 3'h3,
		ST_T3 = 3'h4,
		ST_HOLD = 3'h5
	} bus_state_e;

endpackage : cpu_bus_pkg

// [pin_sync.sv]
/*
 * two-flop synchroniser for a vector of pins; each bit crosses on its own.
 * assumes the pins are quasi-static or sampled only as levels.
 */
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 8
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out
);

	logic [WIDTH-1:0] stage1;

	// first stage is read only by the second
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			stage1 <= '0;
			pin_out <= '0;
		end else begin
			stage1 <= pin_in;
			pin_out <= stage1;
		end
	end

endmodule : pin_sync

// [cpu_bus_interface.sv]
/*
 * processor-side backplane interface: clock division, bus cycle sequencer,
 * status word, wait states, restart address, write strobe gating, bus release.
 * assumes the core issues one cycle request at a time and that memory and
 * I/O boards decode the full address themselves.
 */
// Behaviour
// - the board drives a full 16-bit address so any of 65,536 bytes is selectable.
// - read data comes in on the input bus and write data leaves on a separate output bus.
// - a 16 MHz base is divided to a 4 MHz phase clock and a 2 MHz clock, both driven out.
// - status bits are memory read, input, fetch, output, halt, (unused), write-out, int ack.
// - the eight status lines are presented during every bus cycle.
// - memory cycles get zero, one or two wait states as the wait jumper selects.
// - the restart high byte comes from eight jumpers, open reading one, fitted zero.
// - after any reset the processor restarts fetching from the configured address.
// - the core rate is selected between the 4 MHz and 2 MHz rates by a jumper.
// - address mirroring is on by default and off when its jumper is cut.
// - the memory-write strobe is driven onto the bus only when its enable jumper is fitted.
// - on a bus request the processor stops and floats its address and data outputs.
// - eight vectored priority interrupt lines are accepted and the highest is reported.
// - the I/O space has 256 ports separate from memory.
`timescale 1ns/1ps
module cpu_bus_interface
	import cpu_bus_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic req_valid,
	input wire logic [2:0] req_kind,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [DATA_W-1:0] req_wdata,
	output logic req_taken,
	output logic req_done,
	output logic [DATA_W-1:0] rd_data,
	output logic core_tick,
	output logic irq_pending,
	output logic [2:0] irq_vector,
	output logic [ADDR_W-1:0] addr_out,
	output logic addr_oe,
	output logic [DATA_W-1:0] dout,
	output logic dout_oe,
	output logic [7:0] status,
	output logic status_oe,
	output logic psync,
	output logic pstval_b,
	output logic pdbin,
	output logic pwr_b,
	output logic pwait,
	output logic phlda,
	output logic mwrt,
	output logic mwrt_oe,
	output logic phase_clk,
	output logic slow_clk,
	input wire logic [DATA_W-1:0] din,
	input wire logic rdy,
	input wire logic xrdy,
	input wire logic hold_b,
	input wire logic [IRQ_N-1:0] irq_b,
	input wire logic [1:0] wait_state_jumper,
	input wire logic [7:0] restart_address_jumpers,
	input wire logic core_clock_select_jumper,
	input wire logic address_mirror_jumper,
	input wire logic write_strobe_enable_jumper
);

	localparam int SYNC_W = 3 + IRQ_N + DATA_W + 13;

	logic [SYNC_W-1:0] sync_q;
	logic rdy_s, xrdy_s, hold_s, core_sel_s, mirror_s, wse_s;
	logic [IRQ_N-1:0] irq_s;
	logic [DATA_W-1:0] din_s;
	logic [1:0] wait_sel_s;
	logic [7:0] restart_hi_s;

	pin_sync #(.WIDTH(SYNC_W)) u_sync (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		// active-low pins are inverted ahead of the flops so their reset value reads idle;
		// otherwise a false hold grant and false interrupts follow every reset
		.pin_in({rdy, xrdy, ~hold_b, ~irq_b, din, wait_state_jumper,
			restart_address_jumpers, core_clock_select_jumper,
			address_mirror_jumper, write_strobe_enable_jumper}),
		.pin_out(sync_q)
	);

	assign {rdy_s, xrdy_s, hold_s, irq_s, din_s, wait_sel_s, restart_hi_s,
		core_sel_s, mirror_s, wse_s} = sync_q;

	// clock divider: counter bits give the bus clocks directly
	logic [DIV_W-1:0] div_cnt, next_div_cnt;
	logic tick_phase, tick_slow;

	always_comb begin
		next_div_cnt = div_cnt + DIV_W'(1);
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= next_div_cnt;
		end
	end

	assign phase_clk = div_cnt[$clog2(DIV_PHASE)-1];
	assign slow_clk = div_cnt[DIV_W-1];
	assign tick_phase = (div_cnt[$clog2(DIV_PHASE)-1:0] == '1);
	assign tick_slow = (div_cnt == '1);
	// intact etch (high) keeps the fast rate
	assign core_tick = core_sel_s ? tick_phase : tick_slow;

	// interrupt lines are active low; lowest index wins
	always_comb begin
		irq_vector = 3'h0;
		for (int i = IRQ_N - 1; i >= 0; i--) begin
			if (irq_s[i]) begin
				irq_vector = 3'(i);
			end
		end
	end
	assign irq_pending = |irq_s;

	// bus cycle sequencer
	bus_state_e state, next_state;
	cyc_kind_e kind, next_kind;
	logic [1:0] wcnt, next_wcnt;
	logic first_fetch, next_first_fetch;
	logic [ADDR_W-1:0] next_addr;
	logic [DATA_W-1:0] next_dout, next_rd_data;
	logic [7:0] next_status;
	logic next_done;
	logic hold_req, ready, is_mem, is_read, is_write, in_cycle, data_phase;
	cyc_kind_e rk;

	assign hold_req = hold_s;
	assign ready = rdy_s && xrdy_s;
	assign rk = cyc_kind_e'(req_kind);
	assign is_mem = (kind == CYC_MEM_RD) || (kind == CYC_MEM_WR) || (kind == CYC_FETCH);
	assign is_read = (kind == CYC_MEM_RD) || (kind == CYC_FETCH) || (kind == CYC_IO_IN)
		|| (kind == CYC_INT_ACK);
	assign is_write = (kind == CYC_MEM_WR) || (kind == CYC_IO_OUT);
	assign in_cycle = (state == ST_T1) || data_phase;
	assign data_phase = (state == ST_T2) || (state == ST_TW) || (state == ST_T3);
	assign req_taken = (state == ST_IDLE) && core_tick && !hold_req && req_valid;

	always_comb begin
		next_state = state;
		next_kind = kind;
		next_wcnt = wcnt;
		next_first_fetch = first_fetch;
		next_addr = addr_out;
		next_dout = dout;
		next_rd_data = rd_data;
		next_status = status;
		next_done = 1'b0;
		case (state)
			ST_IDLE: begin
				if (hold_req) begin
					next_state = ST_HOLD;
				end else if (req_taken) begin
					next_state = ST_T1;
					next_kind = rk;
					next_dout = req_wdata;
					next_addr = req_addr;
					if (rk == CYC_IO_IN || rk == CYC_IO_OUT) begin
						// port number on the low byte, copied high when mirroring
						next_addr = {mirror_s ? req_addr[7:0] : IO_HIGH, req_addr[7:0]};
					end else if (rk == CYC_FETCH && first_fetch) begin
						next_addr = {restart_hi_s, RESTART_LOW};
					end
					next_status = '0;
					case (rk)
						CYC_MEM_RD: next_status[ST_MEMR] = 1'b1;
						CYC_MEM_WR: next_status[ST_WO] = 1'b1;
						CYC_IO_IN: next_status[ST_INP] = 1'b1;
						CYC_IO_OUT: begin
							next_status[ST_OUT] = 1'b1;
							next_status[ST_WO] = 1'b1;
						end
						CYC_FETCH: begin
							next_status[ST_MEMR] = 1'b1;
							next_status[ST_M1] = 1'b1;
						end
						CYC_INT_ACK: begin
							next_status[ST_INTA] = 1'b1;
							next_status[ST_M1] = 1'b1;
						end
						CYC_HALT: begin
							next_status[ST_HLTA] = 1'b1;
							next_status[ST_MEMR] = 1'b1;
						end
						default: next_status = '0;
					endcase
				end
			end
			ST_T1: begin
				if (core_tick) begin
					next_state = ST_T2;
					next_wcnt = '0;
					if (is_mem && wait_sel_s == WAIT_ONE) begin
						next_wcnt = WAIT_CNT_ONE;
					end else if (is_mem && wait_sel_s == WAIT_TWO) begin
						next_wcnt = WAIT_CNT_TWO;
					end
				end
			end
			ST_T2: begin
				if (core_tick) begin
					next_state = (wcnt != '0 || !ready) ? ST_TW : ST_T3;
				end
			end
			ST_TW: begin
				if (core_tick) begin
					if (wcnt != '0) begin
						next_wcnt = wcnt - 2'h1;
					end
					if (wcnt <= 2'h1 && ready) begin
						next_state = ST_T3;
					end
				end
			end
			ST_T3: begin
				if (core_tick) begin
					next_state = ST_IDLE;
					next_done = 1'b1;
					if (is_read) begin
						next_rd_data = din_s;
					end
					if (kind == CYC_FETCH) begin
						next_first_fetch = 1'b0;
					end
				end
			end
			ST_HOLD: begin
				if (!hold_req) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_IDLE;
			kind <= CYC_MEM_RD;
			wcnt <= '0;
			first_fetch <= 1'b1;
			addr_out <= '0;
			dout <= '0;
			rd_data <= '0;
			status <= '0;
			req_done <= 1'b0;
		end else begin
			state <= next_state;
			kind <= next_kind;
			wcnt <= next_wcnt;
			first_fetch <= next_first_fetch;
			addr_out <= next_addr;
			dout <= next_dout;
			rd_data <= next_rd_data;
			status <= next_status;
			req_done <= next_done;
		end
	end

	// address, status and data drivers fall off whenever no cycle runs, so a master can take over
	assign addr_oe = in_cycle;
	assign status_oe = in_cycle;
	assign dout_oe = in_cycle && is_write;
	assign psync = (state == ST_T1);
	assign pstval_b = !(state == ST_T1);
	assign pdbin = data_phase && is_read;
	assign pwr_b = !(data_phase && is_write);
	assign pwait = (state == ST_TW);
	assign phlda = (state == ST_HOLD);
	assign mwrt = !pwr_b && (kind == CYC_MEM_WR);
	// line stays floating when the enable jumper is off
	assign mwrt_oe = wse_s;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	sequence s_read_end;
		(state == ST_T3) && core_tick && is_read;
	endsequence

	sequence s_restart_fetch;
		req_taken && rk == CYC_FETCH && first_fetch;
	endsequence

	a_release_bus: assert property (phlda |-> !addr_oe && !dout_oe && !status_oe)
		else $error("bus outputs driven during hold");
	a_read_data: assert property (s_read_end |=> req_done && rd_data == $past(din_s))
		else $error("read data not returned");
	a_status_spare: assert property (status_oe |-> status[5] == 1'b0 && status != '0)
		else $error("status word malformed");
	a_restart_addr: assert property (s_restart_fetch |=> addr_out == {$past(restart_hi_s), RESTART_LOW})
		else $error("restart address wrong");
	a_wait_flag: assert property ((state == ST_TW && !ready) |=> pwait || !rst_b)
		else $error("wait released while not ready");
	a_strobe_gate: assert property (!wse_s |-> !mwrt_oe)
		else $error("write strobe driven without enable");
	a_io_mirror: assert property ((state == ST_T1 && (status[ST_INP] || status[ST_OUT]) && mirror_s)
		|-> addr_out[15:8] == addr_out[7:0])
		else $error("port address not mirrored");
	// phase clock toggles exactly after odd counts; safe across reset release
	a_phase_period: assert property (1'b1 |=> (phase_clk != $past(phase_clk)) == $past(div_cnt[0]))
		else $error("phase clock period wrong");
	a_core_rate: assert property (!core_sel_s |-> core_tick == tick_slow)
		else $error("core rate select ignored");
	a_irq_pending: assert property (irq_s[0] |-> irq_pending && irq_vector == 3'h0)
		else $error("top interrupt not reported");

endmodule : cpu_bus_interface

// [s100_mem_model.sv]
/* far-side memory and I/O board model: full-decode byte store, read return, ready stall.
   assumes the processor board holds address and write data from T1 to T3. */
`timescale 1ns/1ps
module s100_mem_model (
	input wire logic clk_sys,
	input wire logic [15:0] addr_out,
	input wire logic [7:0] dout,
	input wire logic pdbin,
	input wire logic pwr_b,
	input wire logic psync,
	input wire logic [3:0] stall,
	output logic [7:0] din,
	output logic rdy
);
	logic [7:0] mem [0:65535];
	logic [3:0] cnt;
	initial begin
		for (int i = 0; i < 65536; i++) mem[i] = 8'(i ^ (i >> 8) ^ 8'h5A);
		din = 8'h00;
		cnt = 4'h0;
	end
	assign rdy = cnt == 4'h0;
	always @(posedge clk_sys) begin
		// released input lines flip each cycle so stale data cannot pass
		din <= pdbin ? mem[addr_out] : ~din;
		if (!pwr_b) mem[addr_out] <= dout;
		if (psync) cnt <= stall;
		else if (cnt != 4'h0) cnt <= cnt - 4'h1;
	end
endmodule : s100_mem_model

// [s100_cpu_bus_interface_tb_top.sv]
/* self-checking bench for the processor-side backplane interface.
   assumes the memory model answers every address and xrdy stays high. */
`timescale 1ns/1ps
module s100_cpu_bus_interface_tb_top;
	import cpu_bus_pkg::*;
	logic clk_sys = 1'b0, rst_b = 1'b0, xrdy = 1'b1;
	logic req_valid, req_taken, req_done, core_tick, irq_pending, addr_oe, dout_oe, status_oe;
	logic psync, pstval_b, pdbin, pwr_b, pwait, phlda, mwrt, mwrt_oe, phase_clk, slow_clk, rdy;
	logic hold_b, core_clock_select_jumper, address_mirror_jumper, write_strobe_enable_jumper;
	logic [2:0] req_kind, irq_vector;
	logic [15:0] req_addr, addr_out;
	logic [7:0] req_wdata, rd_data, dout, status, din, irq_b, restart_address_jumpers;
	logic [1:0] wait_state_jumper;
	logic [3:0] stall;
	logic [7:0] sh [0:65535];
	int error_cnt = 0, num_checks = 0;
	bit first;
	always #50 clk_sys = ~clk_sys;
	cpu_bus_interface dut (.clk_sys, .rst_b, .req_valid, .req_kind, .req_addr, .req_wdata,
		.req_taken, .req_done, .rd_data, .core_tick, .irq_pending, .irq_vector, .addr_out,
		.addr_oe, .dout, .dout_oe, .status, .status_oe, .psync, .pstval_b, .pdbin, .pwr_b,
		.pwait, .phlda, .mwrt, .mwrt_oe, .phase_clk, .slow_clk, .din, .rdy, .xrdy, .hold_b,
		.irq_b, .wait_state_jumper, .restart_address_jumpers, .core_clock_select_jumper,
		.address_mirror_jumper, .write_strobe_enable_jumper);
	s100_mem_model far_mem (.clk_sys, .addr_out, .dout, .pdbin, .pwr_b, .psync, .stall, .din,
		.rdy);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task final_report;
		if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : final_report
	function automatic logic [7:0] est(input logic [2:0] k);
		est = 8'h00;
		case (k)
			3'h0: est[ST_MEMR] = 1'b1;
			3'h1: est[ST_WO] = 1'b1;
			3'h2: est[ST_INP] = 1'b1;
			3'h3: est = 8'(1 << ST_OUT | 1 << ST_WO);
			3'h4: est = 8'(1 << ST_M1 | 1 << ST_MEMR);
			3'h5: est = 8'(1 << ST_INTA | 1 << ST_M1);
			3'h6: est = 8'(1 << ST_HLTA | 1 << ST_MEMR);
			default: est = 8'h00;
		endcase
	endfunction : est
	function automatic logic [2:0] lowz(input logic [7:0] v);
		for (int i = 7; i >= 0; i--) if (!v[i]) lowz = 3'(i);
	endfunction : lowz
	task automatic cyc(input logic [2:0] k, input logic [15:0] a, input logic [7:0] w);
		logic [15:0] ea;
		int n, pw, ew;
		ea = (k == 3'h2 || k == 3'h3) ? {address_mirror_jumper ? a[7:0] : 8'h00, a[7:0]} : a;
		if (k == 3'h4 && first) ea = {restart_address_jumpers, RESTART_LOW};
		ew = (k < 3'h2 || k == 3'h4) && wait_state_jumper inside {1, 2} ? wait_state_jumper : 0;
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req_kind <= k;
		req_addr <= a;
		req_wdata <= w;
		n = 0;
		do begin @(negedge clk_sys); n++; end while (!req_taken && n < 100);
		@(posedge clk_sys);
		req_valid <= 1'b0;
		pw = 0;
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
			if (psync) begin
				chk(addr_out, ea);
				chk(status, est(k));
				chk(pstval_b, 1'b0);
				chk({addr_oe, status_oe, dout_oe}, {2'b11, k == 3'h1 || k == 3'h3});
				if (k == 3'h1 || k == 3'h3) chk(dout, w);
			end
			if (!pwr_b && k == 3'h1) chk(mwrt, 1'b1);
			pw += pwait;
		end while (!req_done && n < 300);
		chk(req_done, 1'b1);
		if (k == 3'h0 || k == 3'h2 || k == 3'h4) chk(rd_data, sh[ea]);
		else if (k != 3'h5 && k != 3'h6) sh[ea] = w;
		if (stall == 4'h0) chk(16'(pw), 16'(ew * DIV_PHASE));
		else if (k < 3'h5) chk(pw > ew * DIV_PHASE, 1'b1);
		if (k == 3'h4) first = 1'b0;
	endtask : cyc
	task automatic do_reset(input logic [7:0] rj);
		@(posedge clk_sys);
		rst_b <= 1'b0;
		restart_address_jumpers <= rj;
		repeat (8) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk_sys);
		first = 1'b1;
	endtask : do_reset
	task automatic clk_count(input logic sel);
		int p, s, c;
		logic lp, ls;
		@(posedge clk_sys) core_clock_select_jumper <= sel;
		repeat (4) @(negedge clk_sys);
		{p, s, c, lp, ls} = {32'h0, 32'h0, 32'h0, phase_clk, slow_clk};
		repeat (64) begin
			@(negedge clk_sys);
			p += phase_clk & !lp;
			s += slow_clk & !ls;
			c += core_tick;
			{lp, ls} = {phase_clk, slow_clk};
		end
		chk(16'(p), 16'(64 / DIV_PHASE));
		chk(16'(s), 16'(64 / DIV_SLOW));
		chk(16'(c), 16'(sel ? 64 / DIV_PHASE : 64 / DIV_SLOW));
	endtask : clk_count
	initial begin repeat (60000) @(posedge clk_sys); error_cnt++; final_report; end
	initial begin
		void'($urandom(32'h25213A13));
		{req_valid, req_kind, req_addr, req_wdata, hold_b, irq_b} = {28'h0, 1'b1, 8'hFF};
		{wait_state_jumper, core_clock_select_jumper, stall} = {2'h0, 1'b1, 4'h0};
		{address_mirror_jumper, write_strobe_enable_jumper, restart_address_jumpers} = 10'h0;
		for (int i = 0; i < 65536; i++) sh[i] = 8'(i ^ (i >> 8) ^ 8'h5A);
		do_reset(8'hFF);
		cyc(3'h4, 16'h1234, 8'h00);
		clk_count(1'b0);
		clk_count(1'b1);
		for (int j = 0; j < 4; j++) begin
			@(posedge clk_sys);
			wait_state_jumper <= 2'(j);
			address_mirror_jumper <= 1'($urandom);
			write_strobe_enable_jumper <= 1'(j);
			repeat (3) @(posedge clk_sys);
			chk(mwrt_oe, write_strobe_enable_jumper);
			cyc(3'h1, 16'hFFFF, 8'hA5);
			cyc(3'h0, 16'hFFFF, 8'h00);
			repeat (12) cyc(3'($urandom_range(0, 6)), 16'($urandom), 8'($urandom));
		end
		@(posedge clk_sys) stall <= 4'h9;
		cyc(3'h1, 16'h00FF, 8'h3C);
		cyc(3'h0, 16'h00FF, 8'h00);
		@(posedge clk_sys) stall <= 4'h0;
		@(posedge clk_sys) hold_b <= 1'b0;
		repeat (4) @(posedge clk_sys);
		req_valid <= 1'b1;
		repeat (8) begin
			@(negedge clk_sys);
			chk({phlda, addr_oe, dout_oe, status_oe, req_taken}, 5'h10);
		end
		@(posedge clk_sys);
		{req_valid, hold_b} <= 2'b01;
		cyc(3'h3, 16'h0042, 8'h81);
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_sys) irq_b <= i == 0 ? 8'hFF : i == 1 ? 8'h7F : 8'($urandom);
			repeat (4) @(negedge clk_sys);
			chk(irq_pending, ~&irq_b);
			if (!(&irq_b)) chk(irq_vector, lowz(irq_b));
		end
		do_reset(8'h00);
		cyc(3'h4, 16'hBEEF, 8'h00);
		do_reset(8'($urandom));
		cyc(3'h4, 16'h5555, 8'h00);
		final_report;
	end
endmodule : s100_cpu_bus_interface_tb_top
